// >>> hw/aac_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - config bit 7 set selects 12-bit conversion mode, clear leaves it off.
// RULE2 - outside burst, bit 6 set sums conversions; clear keeps only the latest.
// RULE3 - software clears the sum by writing zero to both result bytes.
// RULE4 - accumulate enable is write-only and always reads back as zero.
// RULE5 - bits 5:3 codes 0..3 right-justify, shifting right 0..3 bits.
// RULE6 - code 4 left-justifies, shifting left 4 bits in 12-bit mode or 6 bits otherwise; higher codes are reserved.
// RULE7 - in burst, bits 2:0 select 1,4,8,16,32 or 64 summed conversions.
// RULE8 - software sets repeat count to zero when burst mode is off.
module aac_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire aac_pkg::aac_sfr_req_s sfr_req,
  output logic      [7:0]            sfr_rdata,
  input  wire logic                  burst_mode_en,
  input  wire logic                  conv_done,
  input  wire logic [11:0]           conv_data,
  output logic                       conv_start,
  output logic                       twelve_bit_mode_en,
  output logic                       burst_done
);
  import aac_pkg::*;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  aac_cfg_s   cfg;
  logic [15:0] sum;
  logic [15:0] view;
  logic [6:0]  burst_left;
  aac_state_e  state;
  logic        cfg_wr;
  logic        clr_hi;
  logic        clr_lo;

  assign cfg_wr = sfr_req.wr && sfr_req.addr == ACCUM_CONFIG_ADDR;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg <= aac_cfg_s'(ACCUM_CONFIG_RST);
    end else if (clk_en && cfg_wr) begin
      cfg <= aac_cfg_s'(sfr_req.wdata);
    end
  end

  assign twelve_bit_mode_en = cfg.twelve_bit_mode_en; // [RULE1]

  // ---------------------------------------------------------------
  // zero writes to the result pair
  // ---------------------------------------------------------------
  // both bytes must be written with zero before the sum restarts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clr_hi <= 1'b0;
      clr_lo <= 1'b0;
    end else if (clk_en) begin
      if (sfr_req.wr && sfr_req.addr == RESULT_HIGH_ADDR)
        clr_hi <= (sfr_req.wdata == 8'h00);
      else if (clr_hi && clr_lo)
        clr_hi <= 1'b0;
      if (sfr_req.wr && sfr_req.addr == RESULT_LOW_ADDR)
        clr_lo <= (sfr_req.wdata == 8'h00);
      else if (clr_hi && clr_lo)
        clr_lo <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // burst sequencing
  // ---------------------------------------------------------------
  // reserved repeat codes fall back to one conversion
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= AAC_IDLE;
      burst_left <= 7'h00;
      conv_start <= 1'b0;
      burst_done <= 1'b0;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      burst_done <= 1'b0;
      case (state)
        AAC_IDLE: begin
          if (burst_mode_en && conv_done) begin
            burst_left <= aac_rpt_count(cfg.burst_repeat_count) - 7'h01; // [RULE7]
            if (aac_rpt_count(cfg.burst_repeat_count) == 7'h01)
              burst_done <= 1'b1;
            else begin
              state      <= AAC_BURST;
              conv_start <= 1'b1;
            end
          end
        end
        AAC_BURST: begin
          if (conv_done) begin
            burst_left <= burst_left - 7'h01;
            if (burst_left == 7'h01) begin
              state      <= AAC_IDLE;
              burst_done <= 1'b1;
            end else
              conv_start <= 1'b1;
          end
        end
        default: state <= AAC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // result accumulation
  // ---------------------------------------------------------------
  // a burst starts fresh; a conversion in the clear cycle still counts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sum <= RESULT_RST;
    end else if (clk_en) begin
      if (conv_done) begin
        if (burst_mode_en && state == AAC_IDLE)
          sum <= 16'(conv_data); // [RULE7]
        else if (burst_mode_en || cfg.accumulate_en) begin
          if (clr_hi && clr_lo)
            sum <= 16'(conv_data); // [RULE3]
          else
            sum <= sum + 16'(conv_data); // [RULE2]
        end else
          sum <= 16'(conv_data); // [RULE2]
      end else if (clr_hi && clr_lo) begin
        sum <= RESULT_RST; // [RULE3]
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  aac_format u_format (
    .shift_justify_sel  (cfg.shift_justify_sel),
    .twelve_bit_mode_en (cfg.twelve_bit_mode_en),
    .sum                (sum),
    .view               (view)
  ); // [RULE5] [RULE6]

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en) begin
      if (sfr_req.addr == ACCUM_CONFIG_ADDR)
        sfr_rdata <= {cfg.twelve_bit_mode_en, 1'b0, cfg.shift_justify_sel,
                      cfg.burst_repeat_count}; // [RULE4]
      else if (sfr_req.addr == RESULT_HIGH_ADDR)
        sfr_rdata <= view[15:8];
      else if (sfr_req.addr == RESULT_LOW_ADDR)
        sfr_rdata <= view[7:0];
      else
        sfr_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_accen_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    clk_en && sfr_req.addr == ACCUM_CONFIG_ADDR |=> sfr_rdata[ACCUM_EN_POS] == 1'b0)
    else $error("accumulate enable read back nonzero");
  chk_twelve_follows: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    clk_en && cfg_wr |=> twelve_bit_mode_en == $past(sfr_req.wdata[TWELVE_BIT_POS]))
    else $error("12-bit mode did not follow config write");
  chk_latest_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    clk_en && conv_done && !burst_mode_en && !cfg.accumulate_en
    |=> sum == 16'($past(conv_data)))
    else $error("sum not replaced by latest conversion");
  chk_accum_adds: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    clk_en && conv_done && !burst_mode_en && cfg.accumulate_en && !(clr_hi && clr_lo)
    |=> sum == $past(sum) + 16'($past(conv_data)))
    else $error("sum did not accumulate");
  chk_clear_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    clk_en && clr_hi && clr_lo && !conv_done |=> sum == RESULT_RST)
    else $error("sum not cleared");
  chk_right_shift: assert property (@(posedge sys_clk) // [RULE5]
    cfg.shift_justify_sel <= SJ_MAX_RIGHT |-> view == (sum >> cfg.shift_justify_sel))
    else $error("right justify shift wrong");
  chk_left_just: assert property (@(posedge sys_clk) // [RULE6]
    cfg.shift_justify_sel == SJ_LEFT && cfg.twelve_bit_mode_en |-> view == (sum << 4))
    else $error("left justify wrong");
  chk_burst_single: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    clk_en && state == AAC_IDLE && burst_mode_en && conv_done
    && cfg.burst_repeat_count == 3'h0 |=> burst_done && state == AAC_IDLE)
    else $error("single burst did not finish");
  chk_burst_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    state == AAC_BURST |-> burst_left <= 7'h3F)
    else $error("burst count out of range");
  // view checks carry no reset guard: the formatter is pure wiring
  chk_left_ten: assert property (@(posedge sys_clk) // [RULE6]
    cfg.shift_justify_sel == SJ_LEFT && !cfg.twelve_bit_mode_en |-> view == (sum << 6))
    else $error("10-bit left justify wrong");
  chk_sj_reserved: assert property (@(posedge sys_clk) // [RULE6]
    cfg.shift_justify_sel > SJ_LEFT |-> view == sum)
    else $error("reserved shift code altered the result");
  chk_cfg_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    !clk_en |=> cfg == $past(cfg))
    else $error("config changed while clock enable low");
  chk_cfg_readback: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    clk_en && sfr_req.addr == ACCUM_CONFIG_ADDR
    |=> sfr_rdata[SJ_LSB +: 3] == $past(cfg.shift_justify_sel))
    else $error("shift field read back wrong");
  chk_result_high: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    clk_en && sfr_req.addr == RESULT_HIGH_ADDR |=> sfr_rdata == $past(view[15:8]))
    else $error("result high byte read wrong");
  chk_result_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    clk_en && sfr_req.addr == RESULT_LOW_ADDR |=> sfr_rdata == $past(view[7:0]))
    else $error("result low byte read wrong");
  chk_burst_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    clk_en && state == AAC_IDLE && burst_mode_en && conv_done
    |=> sum == 16'($past(conv_data)))
    else $error("burst did not start from the first conversion");
  chk_burst_last: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    clk_en && state == AAC_BURST && conv_done && burst_left == 7'h01
    |=> burst_done && state == AAC_IDLE)
    else $error("burst did not end after its last conversion");
  chk_clear_done: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    clk_en && clr_hi && clr_lo && !sfr_req.wr |=> !clr_hi && !clr_lo)
    else $error("clear request not retired");
endmodule : aac_top

// >>> hw/aac_pkg.sv
package aac_pkg;
  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ACCUM_CONFIG_ADDR = 8'hBA;
  localparam logic [7:0] RESULT_HIGH_ADDR  = 8'hBE;
  localparam logic [7:0] RESULT_LOW_ADDR   = 8'hBD;
  localparam logic [7:0] ACCUM_CONFIG_RST  = 8'h00;
  localparam int         TWELVE_BIT_POS    = 7;
  localparam int         ACCUM_EN_POS      = 6;
  localparam int         SJ_LSB            = 3;
  localparam int         RPT_LSB           = 0;
  localparam int         RESULT_W          = 16;
  localparam int         SAMPLE_W          = 12;
  localparam logic [2:0] SJ_LEFT           = 3'h4;
  localparam logic [2:0] SJ_MAX_RIGHT      = 3'h3;
  localparam logic [2:0] RPT_MAX           = 3'h5;
  localparam logic [15:0] RESULT_RST       = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       twelve_bit_mode_en;
    logic       accumulate_en;
    logic [2:0] shift_justify_sel;
    logic [2:0] burst_repeat_count;
  } aac_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aac_sfr_req_s;

  typedef enum logic [1:0] {AAC_IDLE, AAC_BURST} aac_state_e;

  // number of conversions for a repeat code
  function automatic logic [6:0] aac_rpt_count(input logic [2:0] code);
    case (code)
      3'h0:    aac_rpt_count = 7'h01;
      3'h1:    aac_rpt_count = 7'h04;
      3'h2:    aac_rpt_count = 7'h08;
      3'h3:    aac_rpt_count = 7'h10;
      3'h4:    aac_rpt_count = 7'h20;
      3'h5:    aac_rpt_count = 7'h40;
      default: aac_rpt_count = 7'h01;
    endcase
  endfunction : aac_rpt_count
endpackage : aac_pkg

// >>> hw/aac_format.sv
`timescale 1ns/100ps
module aac_format (
  input  wire logic [2:0]  shift_justify_sel,
  input  wire logic        twelve_bit_mode_en,
  input  wire logic [15:0] sum,
  output logic      [15:0] view
);
  import aac_pkg::*;
  // left justify puts the sample msb at bit 15; 10-bit results need 6 bits
  always_comb begin
    view = sum;
    if (shift_justify_sel == SJ_LEFT) begin
      if (twelve_bit_mode_en)
        view = sum << 4;
      else
        view = sum << 6;
    end else if (shift_justify_sel <= SJ_MAX_RIGHT) begin
      view = sum >> shift_justify_sel;
    end
  end
endmodule : aac_format

// >>> bench/aac_top_tb.sv
`timescale 1ns/100ps
module aac_top_tb;
  import aac_pkg::*;
  logic         sys_clk;
  logic         rst_n;
  logic         clk_en;
  aac_sfr_req_s sfr_req;
  logic [7:0]   sfr_rdata;
  logic         burst_mode_en;
  logic         conv_done;
  logic [11:0]  conv_data;
  logic         conv_start;
  logic         twelve_bit_mode_en;
  logic         burst_done;
  logic [31:0]  rng;
  logic [15:0]  sum;
  logic [15:0]  v16;
  logic [7:0]   v8;
  logic [7:0]   cfg;
  int           err_total;
  int           checks;
  int           n;
  int           t;

  aac_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .burst_mode_en(burst_mode_en), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start),
    .twelve_bit_mode_en(twelve_bit_mode_en), .burst_done(burst_done));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] j, input logic b);
    if (j <= 3'h3) return s >> j;
    if (j == 3'h4) return b ? s << 4 : s << 6;
    return s;
  endfunction : fmt

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // every bus task starts on a fresh edge so no field is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfr_req.wr <= 1'b1;
    sfr_req.addr <= a;
    sfr_req.wdata <= v;
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
    sfr_req.wdata <= ~v;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    sfr_req.addr <= a;
    @(posedge sys_clk);
    #1 v = sfr_rdata;
  endtask : rd

  task automatic rres(output logic [15:0] v);
    rd(RESULT_HIGH_ADDR, v[15:8]);
    rd(RESULT_LOW_ADDR, v[7:0]);
  endtask : rres

  task automatic clr;
    wr(RESULT_HIGH_ADDR, 8'h00);
    wr(RESULT_LOW_ADDR, 8'h00);
    @(posedge sys_clk);
    sum = 16'h0000;
  endtask : clr

  // data line scrambled outside the strobe so a stale value never looks valid
  task automatic pulse(input logic [11:0] v);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    conv_data <= v;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    conv_data <= ~v;
    sum += 16'(v);
  endtask : pulse

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rng = 32'd57717;
    rst_n = 1'b0;
    clk_en = 1'b1;
    burst_mode_en = 1'b0;
    conv_done = 1'b0;
    conv_data = 12'h000;
    sfr_req = '0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check({13'h0, conv_start, twelve_bit_mode_en, burst_done}, 16'h0000);
    rd(ACCUM_CONFIG_ADDR, v8);
    check({8'h00, v8}, {8'h00, ACCUM_CONFIG_RST});
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      cfg = (k == 0) ? 8'hE0 : {rng[7:6], 3'(rng[5:3] % 3'h5), 3'h0};
      wr(ACCUM_CONFIG_ADDR, cfg);
      rd(ACCUM_CONFIG_ADDR, v8);
      check({8'h00, v8}, {8'h00, cfg & 8'hBF});
      check({15'h0, twelve_bit_mode_en}, {15'h0, cfg[7]});
    end
    for (int j = 0; j < 10; j++) begin
      wr(ACCUM_CONFIG_ADDR, {j[0], 1'b1, 3'(j / 2), 3'h0});
      clr();
      repeat (3) begin
        rng = xs(rng);
        pulse(j[0] ? rng[11:0] : {2'b00, rng[9:0]});
      end
      rres(v16);
      check(v16, fmt(sum, 3'(j / 2), j[0]));
    end
    wr(ACCUM_CONFIG_ADDR, 8'h00);
    pulse(12'h155);
    pulse(12'h0AA);
    rres(v16);
    check(v16, 16'h00AA);
    @(posedge sys_clk);
    burst_mode_en <= 1'b1;
    // code 6 is reserved and should behave as a single conversion
    for (int k = 0; k < 7; k++) begin
      wr(ACCUM_CONFIG_ADDR, {5'h00, 3'(k)});
      clr();
      rng = xs(rng);
      pulse({2'b00, rng[9:0]});
      n = 1;
      t = 0;
      while (t < 40) begin
        #1;
        if (burst_done) break;
        if (conv_start) begin
          rng = xs(rng);
          pulse({2'b00, rng[9:0]});
          n++;
          t = 0;
        end else begin
          @(posedge sys_clk);
          t++;
        end
      end
      if (t >= 40) begin
        err_total++;
        break;
      end
      check(16'(n), (k >= 1 && k <= 5) ? 16'(2 << k) : 16'h0001);
      rres(v16);
      check(v16, sum);
    end
    wr(ACCUM_CONFIG_ADDR, 8'h18);
    @(posedge sys_clk);
    burst_mode_en <= 1'b0;
    clk_en <= 1'b0;
    wr(ACCUM_CONFIG_ADDR, 8'h80);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(ACCUM_CONFIG_ADDR, v8);
    check({8'h00, v8}, 16'h0018);
    // second reset in mid-run must bring back the reset values
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check({13'h0, conv_start, twelve_bit_mode_en, burst_done}, 16'h0000);
    rd(ACCUM_CONFIG_ADDR, v8);
    check({8'h00, v8}, {8'h00, ACCUM_CONFIG_RST});
    rres(v16);
    check(v16, RESULT_RST);
    rd(8'h00, v8);
    check({8'h00, v8}, 16'h0000);
    tally_and_finish();
  end
endmodule : aac_top_tb
